/* hw/wdit_pkg.sv */
// package: register map, field positions and timing constants of the watchdog interval timer
package wdit_pkg;
    localparam int ADDR_W = 8;
    // register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_CLK_SEL = 16'hff42;
    localparam logic [15:0] IDX_MODE = 16'hfff9;
    localparam logic [15:0] IDX_IRQ_STAT = 16'hff00;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hff01;
    localparam logic [17:0] ADDR_CLK_SEL = {IDX_CLK_SEL, 2'b00};
    localparam logic [17:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [17:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [17:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] CLK_SEL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CLK_SEL_MASK = 8'h07;
    localparam logic [7:0] MODE_MASK = 8'h98;
    localparam int RUN_POS = 7;
    localparam int ENABLE_POS = 4;
    localparam int ACTION_POS = 3;
    // status / mask layout
    localparam int ST_INTERVAL = 0;
    localparam int ST_NMI = 1;
    localparam int ST_RESET = 2;
    localparam int ST_BAD_SEL = 3;
    localparam logic [3:0] ST_RST = 4'h0;
    // prescaler and counter widths: divide by up to 2^10, then 2^7 counter steps
    localparam int PRE_W = 10;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;
    // system reset request pulse length
    localparam int RESET_PULSE_NS = 160;
    localparam int CLK_NS = 40;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_COUNT = 2'b01,
        WD_FIRED = 2'b11
    } wdit_state_t;
endpackage

/* hw/wdit_top.sv */
// module: watchdog and interval timer with a classic wishbone register slave
`timescale 1ns/1ps
// ==========================================
// notes
// Notes on behaviour
// - clock codes pick divide 2^4/6/8/10, others prohibited
// - reset clears the clock select register
// - reset clears mode register, timer stopped
// - writing run one clears counter, starts counting
// - run bit cannot be cleared by software
// - enable and action bits are set-only
// - mode field: stop, interval, nmi, reset
// - interval mode counts only after run written
// - runaway detection active while enable bit set, once run written
// - watchdog overflow resets or raises nmi
// - counts in halt, freezes in stop
// - first period after restart may be short
// - pending flag on nmi mode select fires nmi
// - interval mode overflows raise repeating requests
// - interrupt mask gates maskable interval interrupt
module wdit_top
    import wdit_pkg::*;
#(
    parameter int ADR_W = 18
) (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic WB_ACK_O,
    input wire logic CPU_STOP,
    input wire logic WATCHDOG_IRQ_MASK,
    output logic WATCHDOG_IRQ_FLAG,
    input wire logic WATCHDOG_IRQ_FLAG_CLR,
    output logic WATCHDOG_INTERRUPT,
    output logic WATCHDOG_NMI,
    output logic SYSTEM_RESET_REQ,
    output logic IRQ
);
    typedef struct packed {
        logic [7:0] clk_sel;
        logic [7:0] mode;
        logic [PRE_W-1:0] pre;
        logic [CNT_W-1:0] cnt;
        wdit_state_t state;
        logic irq_flag;
        logic nmi;
        logic [2:0] rst_cnt;
        logic [3:0] stat;
        logic [3:0] mask;
        logic ack;
        logic [31:0] rdata;
    } wdit_regs_t;

    wdit_regs_t r_q, r_d;

    // ==========================================
    // helpers
    function automatic logic tick_of(input logic [7:0] sel, input logic [PRE_W-1:0] pre);
        logic t;
        t = 1'b0;
        case (sel[2:0])
            3'b000: t = &pre[3:0];
            3'b010: t = &pre[5:0];
            3'b100: t = &pre[7:0];
            3'b110: t = &pre[9:0];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic hit(input logic [ADR_W-1:0] a, input logic [17:0] ref_a);
        return a == ADR_W'(ref_a);
    endfunction

    logic req, wr, rd, tick, ovf, run_set, byte0;
    logic flag_set, stat_rd;
    logic [3:0] ev;
    logic [7:0] wbyte;

    always_comb begin
        req = WB_CYC_I && WB_STB_I && !r_q.ack;
        wr = req && WB_WE_I;
        rd = req && !WB_WE_I;
        byte0 = WB_SEL_I[0];
        wbyte = WB_DAT_I[7:0];
        tick = tick_of(r_q.clk_sel, r_q.pre);
        ovf = 1'b0;
        run_set = 1'b0;
        flag_set = 1'b0;
        stat_rd = 1'b0;
        ev = 4'h0;
        r_d = r_q;
        r_d.ack = req;

        // ==========================================
        // prescaler free-runs except in stop
        if (!CPU_STOP) begin
            r_d.pre = r_q.pre + PRE_W'(1);
        end

        // ==========================================
        // register writes
        if (wr && byte0) begin
            if (hit(WB_ADR_I, ADDR_CLK_SEL)) begin
                r_d.clk_sel = wbyte & CLK_SEL_MASK;
                if (!(wbyte[0] == 1'b0)) begin
                    ev[ST_BAD_SEL] = 1'b1;
                end
            end else if (hit(WB_ADR_I, ADDR_MODE)) begin
                // set-only bits: or with current value
                r_d.mode = (r_q.mode | wbyte) & MODE_MASK;
                run_set = wbyte[RUN_POS];
                // nmi mode chosen while flag pending fires at once
                if (wbyte[ENABLE_POS] && !r_q.mode[ENABLE_POS] && r_q.irq_flag) begin
                    r_d.nmi = 1'b1;
                    ev[ST_NMI] = 1'b1;
                end
            end else if (hit(WB_ADR_I, ADDR_IRQ_MASK)) begin
                r_d.mask = wbyte[3:0];
            end
        end

        // ==========================================
        // counter state machine
        case (r_q.state)
            WD_IDLE: begin
                r_d.cnt = '0;
                if (run_set) begin
                    r_d.state = WD_COUNT;
                end
            end
            WD_COUNT: begin
                if (run_set) begin
                    r_d.cnt = '0;
                end else if (tick && !CPU_STOP) begin
                    r_d.cnt = r_q.cnt + CNT_W'(1);
                    ovf = (r_q.cnt == CNT_MAX);
                end
            end
            WD_FIRED: begin
                r_d.cnt = '0;
            end
            default: r_d.state = WD_IDLE;
        endcase

        if (ovf) begin
            case (r_q.mode[ENABLE_POS:ACTION_POS])
                2'b01: begin
                    r_d.irq_flag = 1'b1;
                    flag_set = 1'b1;
                    ev[ST_INTERVAL] = 1'b1;
                end
                2'b10: begin
                    r_d.irq_flag = 1'b1;
                    flag_set = 1'b1;
                    r_d.nmi = 1'b1;
                    ev[ST_NMI] = 1'b1;
                end
                2'b11: begin
                    r_d.rst_cnt = 3'(RESET_PULSE_CYC);
                    ev[ST_RESET] = 1'b1;
                    r_d.state = WD_FIRED;
                end
                default: ;
            endcase
        end

        if (r_q.rst_cnt != 3'h0) begin
            r_d.rst_cnt = r_q.rst_cnt - 3'h1;
        end

        // nmi is a one-cycle pulse; flag cleared by interrupt controller, set wins
        if (r_q.nmi) begin
            r_d.nmi = 1'b0;
        end
        if (WATCHDOG_IRQ_FLAG_CLR && !flag_set) begin
            r_d.irq_flag = 1'b0;
        end

        // ==========================================
        // reads; status read clears, new events win
        r_d.rdata = 32'h0;
        if (rd) begin
            if (hit(WB_ADR_I, ADDR_CLK_SEL)) begin
                r_d.rdata = {24'h0, r_q.clk_sel};
            end else if (hit(WB_ADR_I, ADDR_MODE)) begin
                r_d.rdata = {24'h0, r_q.mode};
            end else if (hit(WB_ADR_I, ADDR_IRQ_STAT)) begin
                r_d.rdata = {28'h0, r_q.stat};
                stat_rd = 1'b1;
            end else if (hit(WB_ADR_I, ADDR_IRQ_MASK)) begin
                r_d.rdata = {28'h0, r_q.mask};
            end
        end

        // a status read clears, but an event of the same cycle survives
        r_d.stat = (stat_rd ? 4'h0 : r_q.stat) | ev;

        if (!RST_B) begin
            r_d = '0;
            r_d.clk_sel = CLK_SEL_RST;
            r_d.mode = MODE_RST;
            r_d.stat = ST_RST;
            r_d.state = WD_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        r_q <= r_d;
    end

    assign WB_ACK_O = r_q.ack;
    assign WB_DAT_O = r_q.rdata;
    assign WATCHDOG_IRQ_FLAG = r_q.irq_flag;
    // maskable only in interval mode
    assign WATCHDOG_INTERRUPT = r_q.irq_flag && !WATCHDOG_IRQ_MASK
        && (r_q.mode[ENABLE_POS:ACTION_POS] == 2'b01);
    assign WATCHDOG_NMI = r_q.nmi;
    assign SYSTEM_RESET_REQ = r_q.rst_cnt != 3'h0;
    assign IRQ = |(r_q.stat & r_q.mask);
endmodule

/* tb/wdit_properties.sv */
// checker: port-level properties of the watchdog interval timer
`timescale 1ns/1ps
module wdit_properties (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WATCHDOG_IRQ_MASK,
    input wire logic WATCHDOG_IRQ_FLAG,
    input wire logic WATCHDOG_IRQ_FLAG_CLR,
    input wire logic WATCHDOG_INTERRUPT,
    input wire logic WATCHDOG_NMI,
    input wire logic SYSTEM_RESET_REQ
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
    sequence s_hold; SYSTEM_RESET_REQ [*4] ##1 !SYSTEM_RESET_REQ; endsequence
    a_ack_after_req: assert property (s_req |=> WB_ACK_O) else $error("ack late");
    a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
    a_upper_bits_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper data set");
    a_int_gated: assert property (WATCHDOG_INTERRUPT |-> WATCHDOG_IRQ_FLAG && !WATCHDOG_IRQ_MASK)
        else $error("interrupt not gated");
    a_nmi_pulse: assert property (WATCHDOG_NMI |=> !WATCHDOG_NMI) else $error("nmi long");
    a_reset_hold: assert property ($rose(SYSTEM_RESET_REQ) |-> s_hold)
        else $error("reset request length");
    a_release_quiet: assert property ($rose(RST_B) |-> !WATCHDOG_IRQ_FLAG && !SYSTEM_RESET_REQ)
        else $error("outputs set after reset");
    a_flag_fall: assert property ($fell(WATCHDOG_IRQ_FLAG) |-> $past(WATCHDOG_IRQ_FLAG_CLR) || !$past(RST_B))
        else $error("flag dropped alone");
endmodule
bind wdit_top wdit_properties chk (.SYS_CLK, .RST_B, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .WB_DAT_O,
    .WATCHDOG_IRQ_MASK, .WATCHDOG_IRQ_FLAG, .WATCHDOG_IRQ_FLAG_CLR, .WATCHDOG_INTERRUPT,
    .WATCHDOG_NMI, .SYSTEM_RESET_REQ);

/* tb/tb_top.sv */
// testbench: register, interval, nmi and reset-mode runs of the watchdog interval timer
`timescale 1ns/1ps
module tb_top;
    import wdit_pkg::*;
    logic SYS_CLK = 0, RST_B = 0, WB_WE_I = 0, WB_CYC_I = 0, WB_STB_I = 0, CPU_STOP = 0;
    logic WATCHDOG_IRQ_MASK = 0, WATCHDOG_IRQ_FLAG_CLR = 0;
    logic [17:0] WB_ADR_I = 0;
    logic [31:0] WB_DAT_I = 0, WB_DAT_O, q;
    logic [3:0] WB_SEL_I = 4'hf;
    logic WB_ACK_O, WATCHDOG_IRQ_FLAG, WATCHDOG_INTERRUPT, WATCHDOG_NMI, SYSTEM_RESET_REQ, IRQ;
    int fails = 0, n_checks = 0, seed = 23, n;
    realtime t1;
    wdit_top uut (.SYS_CLK, .RST_B, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_SEL_I, .WB_WE_I,
        .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .CPU_STOP, .WATCHDOG_IRQ_MASK, .WATCHDOG_IRQ_FLAG,
        .WATCHDOG_IRQ_FLAG_CLR, .WATCHDOG_INTERRUPT, .WATCHDOG_NMI, .SYSTEM_RESET_REQ, .IRQ);
    initial forever #20 SYS_CLK = ~SYS_CLK;
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ==========================================
    // bus master: request held until ack is sampled high at a rising edge
    logic [3:0] sel_v = 4'hf;
    task automatic wb(input logic we, input logic [17:0] a, input logic [31:0] d);
        WB_CYC_I <= 1;
        WB_STB_I <= 1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        WB_SEL_I <= sel_v;
        do begin
            @(posedge SYS_CLK);
        end while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        WB_CYC_I <= 0;
        WB_STB_I <= 0;
        WB_WE_I <= 0;
        @(posedge SYS_CLK);
    endtask
    task automatic rd(input string nm, input logic [17:0] a, input logic [31:0] e);
        wb(0, a, 0);
        chk(nm, e, q);
    endtask
    // waits for flag (0), nmi (1) or reset request (2); n counts cycles
    task automatic wt(input int s);
        logic [2:0] v;
        n = 0;
        v = 3'b000;
        do begin
            @(negedge SYS_CLK);
            n++;
            v = {SYSTEM_RESET_REQ, WATCHDOG_NMI, WATCHDOG_IRQ_FLAG};
        end while (v[s] !== 1'b1 && n < 40000);
        @(posedge SYS_CLK);
    endtask
    // model: overflow period in clocks for a legal clock code
    function automatic int period_of(input int code);
        return 1 << (11 + code);
    endfunction
    // model: first period after a restart may be up to 0.8% short
    function automatic logic first_ok(input int code, input int cyc);
        int p;
        p = period_of(code);
        return cyc >= p - (p * 8) / 1000 - 2 && cyc <= p;
    endfunction
    task automatic do_reset();
        RST_B <= 0;
        repeat (2) @(posedge SYS_CLK);
        RST_B <= 1;
        @(posedge SYS_CLK);
    endtask
    initial begin
        repeat (60000) @(posedge SYS_CLK);
        fails++;
        finish_test();
    end
    initial begin
        do_reset();
        rd("sel", ADDR_CLK_SEL, 32'h0);
        rd("mode", ADDR_MODE, 32'h0);
        wb(1, 18'h00010, $random(seed));
        rd("unmapped", 18'h00010, 32'h0);
        wb(1, ADDR_CLK_SEL, $random(seed) & 32'hf8);
        rd("sel_fix", ADDR_CLK_SEL, 32'h0);
        wb(1, ADDR_CLK_SEL, 32'h1);
        rd("bad_code", ADDR_IRQ_STAT, 32'h8);
        rd("stat_clr", ADDR_IRQ_STAT, 32'h0);
        wb(1, ADDR_CLK_SEL, 32'h0);
        sel_v = 4'he;
        wb(1, ADDR_IRQ_MASK, 32'hf);
        sel_v = 4'hf;
        rd("lane_off", ADDR_IRQ_MASK, 32'h0);
        wb(1, ADDR_IRQ_MASK, 32'h1);
        rd("mask", ADDR_IRQ_MASK, 32'h1);
        wb(1, ADDR_MODE, 32'h88);
        wt(0);
        t1 = $realtime;
        chk("first_period", 1, first_ok(0, n));
        chk("irq", 1, IRQ);
        chk("int", 1, WATCHDOG_INTERRUPT);
        WATCHDOG_IRQ_MASK <= 1;
        @(posedge SYS_CLK);
        chk("int_masked", 0, WATCHDOG_INTERRUPT);
        wb(1, ADDR_MODE, 32'h0);
        rd("set_only", ADDR_MODE, 32'h88);
        rd("stat", ADDR_IRQ_STAT, 32'h1);
        chk("irq_clr", 0, IRQ);
        WATCHDOG_IRQ_FLAG_CLR <= 1;
        @(posedge SYS_CLK);
        WATCHDOG_IRQ_FLAG_CLR <= 0;
        wt(0);
        chk("period", 1, int'(($realtime - t1) / 40) == period_of(0));
        wb(1, ADDR_MODE, 32'h10);
        rd("nmi_pend", ADDR_IRQ_STAT, 32'h3);
        rd("set_only2", ADDR_MODE, 32'h98);
        do_reset();
        rd("mode_rst", ADDR_MODE, 32'h0);
        wb(1, ADDR_CLK_SEL, 32'h2);
        wb(1, ADDR_MODE, 32'h90);
        wb(1, ADDR_MODE, 32'h80);
        CPU_STOP <= 1;
        repeat (500) @(posedge SYS_CLK);
        CPU_STOP <= 0;
        wt(1);
        chk("nmi_time", 1, first_ok(2, n));
        rd("nmi_stat", ADDR_IRQ_STAT, 32'h2);
        wb(1, ADDR_CLK_SEL, 32'h0);
        repeat (3) begin
            wb(1, ADDR_MODE, 32'h80);
            repeat (1500) @(posedge SYS_CLK);
        end
        rd("kicked", ADDR_IRQ_STAT, 32'h0);
        do_reset();
        wb(1, ADDR_CLK_SEL, 32'h4);
        wb(1, ADDR_MODE, 32'h98);
        wt(2);
        chk("rst_time", 1, first_ok(4, n));
        chk("rst_req", 1, SYSTEM_RESET_REQ);
        rd("rst_stat", ADDR_IRQ_STAT, 32'h4);
        repeat (4) @(posedge SYS_CLK);
        chk("rst_end", 0, SYSTEM_RESET_REQ);
        finish_test();
    end
endmodule
